// File: src/rmc_pkg.sv
// Package: offsets, field positions, reset values and states of the receive mode control word block
package rmc_pkg;
  // Byte offsets on the Wishbone register bus
  localparam logic [3:0] RMC_OFF_CTRL   = 4'h0;
  localparam logic [3:0] RMC_OFF_STATUS = 4'h4;
  localparam logic [3:0] RMC_OFF_MASK   = 4'h8;
  localparam logic [3:0] RMC_OFF_GLOBAL = 4'hC;
  // Control word field positions
  localparam int RMC_BIT_IDX_ZERO = 15;
  localparam int RMC_BIT_ACCESS   = 14;
  localparam int RMC_BIT_BCRX     = 13;
  localparam int RMC_BIT_BUSY     = 12;
  localparam int RMC_BIT_ACCESSED = 11;
  localparam int RMC_BIT_SEL_B    = 10;
  localparam int RMC_BIT_BC_SEEN  = 9;
  localparam int RMC_BIT_STOP_REQ = 3;
  // Global register field positions
  localparam int RMC_GBL_IDX_ZERO_EN = 0;
  localparam int RMC_GBL_ACCESS_EN = 1;
  localparam int RMC_GBL_BCRX_EN   = 2;
  localparam int RMC_GBL_BC_DIS    = 3;
  localparam int RMC_GBL_EXEC      = 4;
  localparam int RMC_GBL_SOFT_RST  = 5;
  // Status and mask bit positions
  localparam int RMC_ST_IDX_ZERO = 0;
  localparam int RMC_ST_ACCESS = 1;
  localparam int RMC_ST_BCRX   = 2;
  // Reset values
  localparam logic [15:0] RMC_CTRL_RST   = 16'h0000;
  localparam logic [2:0]  RMC_IRQ_RST    = 3'h0;
  localparam logic [4:0]  RMC_GLOBAL_RST = 5'h00;
  // Host-writable control word bits: 15..12 and 3
  localparam logic [15:0] RMC_HOST_WMASK = 16'hF008;
  // Terminal address used for broadcast, mode code subaddresses
  localparam logic [4:0] RMC_BC_ADDR    = 5'h1F;
  localparam logic [4:0] RMC_SA_MODE0   = 5'h00;
  localparam logic [4:0] RMC_SA_MODE31  = 5'h1F;
  localparam logic [4:0] RMC_MC_DATA_LO = 5'h10;

  typedef enum logic [1:0] {
    RMC_BUS_IDLE,
    RMC_BUS_ACK
  } rmc_bus_t;
endpackage

// File: src/rmc_cmd_decode.sv
// Command classifier: decides whether a finished command applies to this control word
`timescale 1ns/1ps
module rmc_cmd_decode
  import rmc_pkg::*;
(
  input  wire logic       tr_bit,
  input  wire logic [4:0] subaddr,
  input  wire logic [4:0] term_addr,
  input  wire logic [4:0] mode_code,
  input  wire logic       bc_disable,
  output logic            applies,
  output logic            is_broadcast_seen,
  output logic            has_data
);
  logic addr_bc;

  always_comb begin
    addr_bc  = (term_addr == RMC_BC_ADDR);
    // broadcast disabled makes address 31 invalid
    applies  = !tr_bit && (subaddr == RMC_SA_MODE0 || subaddr == RMC_SA_MODE31) && !(addr_bc && bc_disable);
    is_broadcast_seen = applies && addr_bc;
    has_data = mode_code >= RMC_MC_DATA_LO;
  end
endmodule

// File: src/rmc_ctrl_word.sv
// Receive mode command control word with status flags, ping-pong select and interrupts
`timescale 1ns/1ps
module rmc_ctrl_word
  import rmc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        master_reset_in,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Command completion from the protocol engine
  input  wire logic        cmd_done,
  input  wire logic        cmd_error,
  input  wire logic        cmd_illegal,
  input  wire logic        cmd_tr_bit,
  input  wire logic [4:0]  cmd_subaddr,
  input  wire logic [4:0]  cmd_term_addr,
  input  wire logic [4:0]  cmd_mode_code,
  input  wire logic        ping_pong_mode,
  input  wire logic        index_reached_zero,
  input  wire logic        global_busy,
  // Answers to the protocol engine
  output logic             busy_response,
  output logic             store_data_word,
  output logic             use_pointer_b,
  output logic             message_irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rmc_bus_t    bus;
    logic [31:0] rdata;
    logic        ack;
    logic [15:0] ctrl;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [4:0]  gcfg;
    logic        busy;
    logic        store;
    logic        ptr_b;
    logic        irq;
    logic        mr_s1;
    logic        mr_s2;
  } rmc_state_t;

  rmc_state_t st;
  rmc_state_t next_st;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic applies;
  logic is_broadcast_seen;
  logic has_data;

  rmc_cmd_decode u_dec (
    .tr_bit     (cmd_tr_bit),
    .subaddr    (cmd_subaddr),
    .term_addr  (cmd_term_addr),
    .mode_code  (cmd_mode_code),
    .bc_disable (st.gcfg[RMC_GBL_BC_DIS]),
    .applies    (applies),
    .is_broadcast_seen   (is_broadcast_seen),
    .has_data   (has_data)
  );

  // ----------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------
  logic        req;
  logic        req_wr;
  logic        req_rd;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_gcfg;
  logic        soft_rst;
  logic [15:0] wmask;

  always_comb begin
    // Only a request seen in idle is taken; the one still held in the ack cycle is not
    req       = wb_cyc_i && wb_stb_i && (st.bus == RMC_BUS_IDLE);
    req_wr    = req && wb_we_i;
    req_rd    = req && !wb_we_i;

    wr_ctrl   = req_wr && (wb_adr_i == RMC_OFF_CTRL);
    rd_ctrl   = req_rd && (wb_adr_i == RMC_OFF_CTRL);
    // Status, mask and global fields all sit in byte lane 0
    wr_status = req_wr && (wb_adr_i == RMC_OFF_STATUS) && wb_sel_i[0];
    wr_mask   = req_wr && (wb_adr_i == RMC_OFF_MASK) && wb_sel_i[0];
    wr_gcfg   = req_wr && (wb_adr_i == RMC_OFF_GLOBAL) && wb_sel_i[0];

    // Soft reset is a write-one strobe and is never stored
    soft_rst  = wr_gcfg && wb_dat_i[RMC_GBL_SOFT_RST];

    // only bits 15..12 and 3 are host writable
    wmask     = {(wb_sel_i[1] ? 8'hFF : 8'h00), (wb_sel_i[0] ? 8'hFF : 8'h00)} & RMC_HOST_WMASK;
  end

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    case (wb_adr_i)
      RMC_OFF_CTRL:   rd_val = {16'h0000, st.ctrl};
      RMC_OFF_STATUS: rd_val = {29'h0, st.status};
      RMC_OFF_MASK:   rd_val = {29'h0, st.mask};
      RMC_OFF_GLOBAL: rd_val = {27'h0, st.gcfg};
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Completion qualifiers
  // ----------------------------------------------------------------
  logic done_any;
  logic done_ok;
  logic busy_now;

  always_comb begin
    // per-code busy independent of global busy
    busy_now = st.ctrl[RMC_BIT_BUSY] || global_busy;
    // Illegal commands and a stopped terminal leave the word untouched
    done_any = cmd_done && applies && !cmd_illegal && st.gcfg[RMC_GBL_EXEC];
    // errors and Busy hold the select
    done_ok  = done_any && !cmd_error && !busy_now;
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic [2:0] events;

  always_comb begin
    events[RMC_ST_ACCESS]   = done_any && st.ctrl[RMC_BIT_ACCESS] && st.gcfg[RMC_GBL_ACCESS_EN];
    // index zero event, indexed mode only
    events[RMC_ST_IDX_ZERO] = done_any && !ping_pong_mode && index_reached_zero
                              && st.ctrl[RMC_BIT_IDX_ZERO] && st.gcfg[RMC_GBL_IDX_ZERO_EN];
    events[RMC_ST_BCRX]     = done_any && is_broadcast_seen && st.ctrl[RMC_BIT_BCRX] && st.gcfg[RMC_GBL_BCRX_EN];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;

    // ------------------------------
    // Master reset synchroniser
    // ------------------------------
    next_st.mr_s1 = master_reset_in;
    next_st.mr_s2 = st.mr_s1;

    // ------------------------------
    // Bus reply
    // ------------------------------
    // Registered ack costs one wait state but keeps the bus outputs glitch free
    case (st.bus)
      RMC_BUS_IDLE: begin
        next_st.ack = 1'b0;
        if (req) begin
          next_st.bus = RMC_BUS_ACK;
          next_st.ack = 1'b1;
        end
      end
      RMC_BUS_ACK: begin
        next_st.bus = RMC_BUS_IDLE;
        next_st.ack = 1'b0;
      end
      default: begin
        next_st.bus = RMC_BUS_IDLE;
        next_st.ack = 1'b0;
      end
    endcase
    if (req_rd) begin
      next_st.rdata = rd_val;
    end

    // ------------------------------
    // Host writes
    // ------------------------------
    // device-owned bits keep their value
    if (wr_ctrl) begin
      next_st.ctrl = (st.ctrl & ~wmask) | (wb_dat_i[15:0] & wmask);
    end
    if (wr_mask) begin
      next_st.mask = wb_dat_i[2:0];
    end
    if (wr_gcfg) begin
      next_st.gcfg = wb_dat_i[4:0];
    end

    // ------------------------------
    // Host clears of the flags
    // ------------------------------
    // read clears block accessed
    if (rd_ctrl) begin
      next_st.ctrl[RMC_BIT_ACCESSED] = 1'b0;
    end
    // soft reset touches only flags and select
    if (soft_rst) begin
      next_st.ctrl[RMC_BIT_ACCESSED] = 1'b0;
      next_st.ctrl[RMC_BIT_SEL_B]    = 1'b0;
      next_st.ctrl[RMC_BIT_BC_SEEN]  = 1'b0;
    end

    // ------------------------------
    // Device updates at completion
    // ------------------------------
    // Placed after the host clears so that a completion in the same cycle wins
    if (done_any) begin
      // completion sets flag, over a read clear
      next_st.ctrl[RMC_BIT_ACCESSED] = 1'b1;
      if (is_broadcast_seen) begin
        next_st.ctrl[RMC_BIT_BC_SEEN] = 1'b1;
      end
      if (done_ok && ping_pong_mode) begin
        next_st.ctrl[RMC_BIT_SEL_B] = ~st.ctrl[RMC_BIT_SEL_B];
      end
    end

    // ------------------------------
    // Pending interrupts
    // ------------------------------
    // pending bits sticky, set beats write-one clear
    if (wr_status) begin
      next_st.status = st.status & ~wb_dat_i[2:0];
    end
    next_st.status = next_st.status | events;
    // A new mask acts on the same edge as its write
    next_st.irq    = |(next_st.status & next_st.mask);

    // ------------------------------
    // Engine answers
    // ------------------------------
    // Answers follow the fields of the command in flight
    next_st.busy  = applies && busy_now;
    // no data word stored while Busy
    next_st.store = applies && has_data && !busy_now;
    // pointer select only in ping-pong mode
    next_st.ptr_b = ping_pong_mode && next_st.ctrl[RMC_BIT_SEL_B];

    // ------------------------------
    // Master reset
    // ------------------------------
    // Mask and global setup survive so the host need not reload them
    if (st.mr_s2) begin
      next_st.ctrl   = RMC_CTRL_RST;
      next_st.status = RMC_IRQ_RST;
      next_st.irq    = 1'b0;
      next_st.ptr_b  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st        <= '0;
      st.bus    <= RMC_BUS_IDLE;
      st.ctrl   <= RMC_CTRL_RST;
      st.status <= RMC_IRQ_RST;
      st.mask   <= RMC_IRQ_RST;
      st.gcfg   <= RMC_GLOBAL_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Plain copies of state bits, so every output comes from a flip-flop
  always_comb begin
    wb_dat_o        = st.rdata;
    wb_ack_o        = st.ack;
    busy_response   = st.busy;
    store_data_word = st.store;
    use_pointer_b   = st.ptr_b;
    message_irq_out = st.irq;
  end
endmodule

// File: bench/rmc_ctrl_word_sva.sv
// Port checker for the receive mode control word block
`timescale 1ns/1ps
module rmc_ctrl_word_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       master_reset_in,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       cmd_done,
  input wire logic       cmd_error,
  input wire logic       cmd_tr_bit,
  input wire logic [4:0] cmd_subaddr,
  input wire logic [4:0] cmd_term_addr,
  input wire logic [4:0] cmd_mode_code,
  input wire logic       ping_pong_mode,
  input wire logic       global_busy,
  input wire logic       busy_response,
  input wire logic       store_data_word,
  input wire logic       use_pointer_b,
  input wire logic       message_irq_out
);
  // Receive mode command to a non-broadcast address, so broadcast disable cannot matter
  wire logic rx_mc = !cmd_tr_bit && cmd_subaddr == 5'h00 && cmd_term_addr != 5'h1F;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------
  // Properties
  // ----------------
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_take |=> s_pulse; endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one pulse");
  property p_gbusy; global_busy && rx_mc |=> busy_response; endproperty
  a_gbusy: assert property (p_gbusy) else $error("busy answer missing");
  property p_rx_only; cmd_tr_bit |=> !busy_response && !store_data_word; endproperty
  a_rx_only: assert property (p_rx_only) else $error("transmit command handled");
  property p_nostore; global_busy |=> !store_data_word; endproperty
  a_nostore: assert property (p_nostore) else $error("data stored while busy");
  property p_store_hi; store_data_word |-> $past(cmd_mode_code) >= 5'h10; endproperty
  a_store_hi: assert property (p_store_hi) else $error("data stored for low code");
  property p_idx; !ping_pong_mode [*2] |-> !use_pointer_b; endproperty
  a_idx: assert property (p_idx) else $error("pointer B in indexed mode");
  property p_hold;
    cmd_done && (cmd_error || global_busy) && !master_reset_in && $stable(ping_pong_mode) |=> $stable(use_pointer_b);
  endproperty
  a_hold: assert property (p_hold) else $error("select moved on error or busy");
  property p_mr; master_reset_in [*6] |-> !use_pointer_b && !message_irq_out; endproperty
  a_mr: assert property (p_mr) else $error("state kept through master reset");
endmodule
bind rmc_ctrl_word rmc_ctrl_word_sva i_sva (.*);

// File: bench/rmc_engine_model.sv
// Protocol engine stand-in that presents finished commands
`timescale 1ns/1ps
module rmc_engine_model (
  input wire logic  core_clk,
  output logic       cmd_done,
  output logic       cmd_error,
  output logic       cmd_illegal,
  output logic       cmd_tr_bit,
  output logic [4:0] cmd_subaddr,
  output logic [4:0] cmd_term_addr,
  output logic [4:0] cmd_mode_code,
  output logic       index_reached_zero
);
  initial {cmd_done, cmd_error, cmd_illegal, index_reached_zero, cmd_tr_bit} = 5'h01;
  initial {cmd_subaddr, cmd_term_addr, cmd_mode_code} = 15'h0000;
  // Idle fields carry a transmit command so they never look like a receive mode command
  task automatic send(input logic [2:0] eii, input logic tr, input logic [4:0] sa, ta, mc, input int gap);
    repeat (gap) @(posedge core_clk);
    {cmd_error, cmd_illegal, index_reached_zero, cmd_tr_bit, cmd_subaddr, cmd_term_addr, cmd_mode_code} <= {eii, tr, sa, ta, mc};
    cmd_done <= 1'b1;
    @(posedge core_clk);
    cmd_done <= 1'b0;
    {cmd_error, cmd_illegal, index_reached_zero, cmd_tr_bit, cmd_subaddr, cmd_term_addr, cmd_mode_code} <= {~eii, 1'b1, ~sa, ~ta, ~mc};
  endtask
endmodule

// File: bench/rmc_ctrl_word_test.sv
// Self-checking bench for the receive mode control word block
`timescale 1ns/1ps
module rmc_ctrl_word_test;
  import rmc_pkg::*;
  logic        core_clk = 1'b0, rst = 1'b1, master_reset_in = 1'b0, ping_pong_mode = 1'b1, global_busy = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic        cmd_done, cmd_error, cmd_illegal, cmd_tr_bit, index_reached_zero;
  logic [4:0]  cmd_subaddr, cmd_term_addr, cmd_mode_code;
  logic        busy_response, store_data_word, use_pointer_b, message_irq_out;
  int          miscompares = 0, samples_checked = 0;
  rmc_ctrl_word i_dut (.*);
  rmc_engine_model i_eng (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
  // ----------------
  // Test sequence
  // ----------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(RMC_OFF_CTRL, 32'h0);
    rd(4'h2, 32'h0);
    wb(1'b1, RMC_OFF_CTRL, 32'hFFFF, 4'h1);
    rd(RMC_OFF_CTRL, 32'h0008);
    wb(1'b1, RMC_OFF_CTRL, 32'hFFFF);
    rd(RMC_OFF_CTRL, 32'hF008);
    wb(1'b1, RMC_OFF_GLOBAL, 32'h17);
    wb(1'b1, RMC_OFF_MASK, 32'h7);
    wb(1'b1, RMC_OFF_CTRL, 32'hE000);
    i_eng.send(3'b000, 1'b0, 5'h00, 5'h05, 5'h11, 1);
    #1 chk({store_data_word, use_pointer_b, message_irq_out}, 3'b111);
    rd(RMC_OFF_CTRL, 32'hEC00);
    rd(RMC_OFF_CTRL, 32'hE400);
    rd(RMC_OFF_STATUS, 32'h2);
    wb(1'b1, RMC_OFF_STATUS, 32'h2);
    rd(RMC_OFF_STATUS, 32'h0);
    chk(message_irq_out, 1'b0);
    i_eng.send(3'b000, 1'b0, 5'h1F, 5'h1F, 5'h02, 3);
    rd(RMC_OFF_CTRL, 32'hEA00);
    rd(RMC_OFF_STATUS, 32'h6);
    chk(use_pointer_b, 1'b0);
    wb(1'b1, RMC_OFF_STATUS, 32'h6);
    i_eng.send(3'b100, 1'b0, 5'h00, 5'h05, 5'h01, 1);
    i_eng.send(3'b010, 1'b0, 5'h00, 5'h05, 5'h01, 1);
    global_busy <= 1'b1;
    i_eng.send(3'b000, 1'b0, 5'h00, 5'h05, 5'h14, 1);
    #1 chk({busy_response, store_data_word, use_pointer_b}, 3'b100);
    wb(1'b1, RMC_OFF_CTRL, 32'hF000);
    global_busy <= 1'b0;
    i_eng.send(3'b000, 1'b0, 5'h00, 5'h05, 5'h14, 1);
    #1 chk({busy_response, store_data_word}, 2'b10);
    wb(1'b0, RMC_OFF_CTRL, 32'h0);
    chk(rdat & 32'h0400, 32'h0);
    wb(1'b1, RMC_OFF_GLOBAL, 32'h37);
    rd(RMC_OFF_CTRL, 32'hF000);
    rd(RMC_OFF_GLOBAL, 32'h17);
    wb(1'b1, RMC_OFF_CTRL, 32'hE000);
    ping_pong_mode <= 1'b0;
    i_eng.send(3'b001, 1'b0, 5'h00, 5'h05, 5'h03, 1);
    rd(RMC_OFF_STATUS, 32'h3);
    rd(RMC_OFF_CTRL, 32'hE800);
    wb(1'b1, RMC_OFF_MASK, 32'h0);
    rd(RMC_OFF_MASK, 32'h0);
    chk(message_irq_out, 1'b0);
    wb(1'b1, RMC_OFF_GLOBAL, 32'h1F);
    i_eng.send(3'b000, 1'b0, 5'h00, 5'h1F, 5'h01, 1);
    i_eng.send(3'b000, 1'b1, 5'h00, 5'h05, 5'h01, 1);
    rd(RMC_OFF_CTRL, 32'hE000);
    ping_pong_mode <= 1'b1;
    wb(1'b1, RMC_OFF_GLOBAL, 32'h17);
    i_eng.send(3'b000, 1'b0, 5'h00, 5'h05, 5'h01, 1);
    master_reset_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    master_reset_in <= 1'b0;
    rd(RMC_OFF_CTRL, 32'h0);
    chk(use_pointer_b, 1'b0);
    complete_run;
  end
endmodule
